// ### ck_console_map.vh
/*
  constants for the console key control block: register offsets,
  field positions, reset values and timing counts.
  assumes the includer runs on a 10 ns clock.
*/
`ifndef CK_CONSOLE_MAP_VH
`define CK_CONSOLE_MAP_VH

`define CK_CLK_PERIOD_NS 10
`define CK_ANY_KEY_NS 3000
`define CK_ANY_KEY_CYC ((`CK_ANY_KEY_NS + `CK_CLK_PERIOD_NS - 1) / `CK_CLK_PERIOD_NS)
`define CK_STAGE_MS 25
`define CK_STAGE_CYC (`CK_STAGE_MS * 1000000 / `CK_CLK_PERIOD_NS)
`define CK_LOCK_MS 30
`define CK_LOCK_CYC (`CK_LOCK_MS * 1000000 / `CK_CLK_PERIOD_NS)
`define CK_CNT_W 22

`define CK_NKEYS 9
`define CK_KEY_CLEAR 0
`define CK_KEY_RESET 1
`define CK_KEY_START 2
`define CK_KEY_SSTEP 3
`define CK_KEY_MSTEP 4
`define CK_KEY_DISPLAY 5
`define CK_KEY_ENTER 6
`define CK_KEY_EXEC_ONCE 7
`define CK_KEY_LOAD 8
`define CK_AUTO_MASK 9'h107
`define CK_MANUAL_MASK 9'h1FE

`define CK_OFS_CTRL 8'h00
`define CK_OFS_STATUS 8'h04
`define CK_CTRL_OVERRIDE 0
`define CK_CTRL_TIMER 1
`define CK_CTRL_CWBE 2
`define CK_CTRL_RESET 3'h0

`define CK_ST_MASTER_STOP 0
`define CK_ST_PROGRAM_STOP 1
`define CK_ST_START 2
`define CK_ST_RESET 3
`define CK_ST_MANUAL 4
`define CK_ST_MSTEP 5
`define CK_ST_ANY_KEY 6

`endif

// ### ck_console_key_control.v
/*
  console key control: turns synchronised operator keys into timed
  key-activation pulses, single and multiple step pulses, and keeps the
  automatic/manual status with the master-stop, program-stop, start and
  reset triggers; an ahb-lite slave holds the console switch register.
  assumes timing-ring pulses, early i-cycle, halt and channel-in-use
  come from logic on hclk; keys and the automatic switch are async pins.
*/
// Operation
// [RL1] any logical key gives 3 us pulse
// [RL2] single step: pulse, step only if unstopped
// [RL3] halt sets program stop, steps blocked
// [RL4] held multiple step repeats every 50 ms
// [RL5] 50 ms from two chained 25 ms stages
// [RL6] manual stops after current instruction, channels permitting
// [RL7] manual and allowed sets master stop at i1d2
// [RL8] interval timer runs regardless of status
// [RL9] automatic honours clear, reset, start, load only
// [RL10] manual key set; start only clears program stop
// [RL11] channel busy without override forces automatic
// [RL12] override masks channel busy, stays manual
// [RL13] override lamp follows override
// [RL14] start sets start trigger, clears at a5d1
// [RL15] automatic start clears master stop at a4d2
// [RL16] start resumes execution only in automatic
// [RL17] word-bank execute replaces fetch from storage
// [RL18] word-bank execute lamp lit, works manual
// [RL19] reset key works both statuses, spares storage
// [RL20] reset trigger set a3d1, cleared a2d1
// [RL21] interlock reset clears channel and cpu state
// [RL22] interlock reset sets stop and end triggers
// [RL23] keys synchronised and edge detected once
// [RL24] clear key ignored in manual
`include "ck_console_map.vh"

module ck_console_key_control #(
  parameter [`CK_CNT_W-1:0] STAGE_CYC = `CK_STAGE_CYC,
  parameter [`CK_CNT_W-1:0] LOCK_CYC = `CK_LOCK_CYC
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire [`CK_NKEYS-1:0] key_pins,
  input wire automatic_switch,
  input wire power_on_reset,
  input wire pulse_i1d2,
  input wire pulse_a2d1,
  input wire pulse_a3d1,
  input wire pulse_a4d2,
  input wire pulse_a5d1,
  input wire early_i_cycle,
  input wire halt_instruction,
  input wire channel_in_use,
  output reg any_key_pulse,
  output reg step_pulse,
  output reg [`CK_NKEYS-1:0] key_op,
  output reg master_stop,
  output reg program_stop,
  output reg start_trigger,
  output reg reset_trigger,
  output reg interlock_reset,
  output wire channel_reset_command,
  output wire manual_status,
  output wire inhibit_ic_step,
  output wire inhibit_mdr_to_bus,
  output wire word_bank_to_bus,
  output wire override_lamp,
  output wire word_bank_lamp,
  output wire interval_timer_run
);

  localparam [2:0] MS_IDLE = 3'h1;
  localparam [2:0] MS_STAGE1 = 3'h2;
  localparam [2:0] MS_STAGE2 = 3'h4;
  localparam [`CK_CNT_W-1:0] ANY_CYC = `CK_ANY_KEY_CYC;
  localparam [`CK_CNT_W-1:0] CNT_ONE = 22'h000001;

  // key synchronisers, three flops each
  reg [`CK_NKEYS-1:0] s1_reg;
  reg [`CK_NKEYS-1:0] s2_reg;
  reg [`CK_NKEYS-1:0] s3_reg;
  reg [`CK_NKEYS-1:0] key_lvl_reg;
  wire [`CK_NKEYS-1:0] key_press;
  reg as1_reg;
  reg as2_reg;
  reg as3_reg;
  reg auto_sw_reg;

  genvar gi;
  generate
    for (gi = 0; gi < `CK_NKEYS; gi = gi + 1) begin : g_key
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          s1_reg[gi] <= 1'b0;
          s2_reg[gi] <= 1'b0;
          s3_reg[gi] <= 1'b0;
          key_lvl_reg[gi] <= 1'b0;
        end else begin
          s1_reg[gi] <= key_pins[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          if (s2_reg[gi] == s3_reg[gi]) begin
            key_lvl_reg[gi] <= s3_reg[gi];
          end
        end
      end
      // one press per rising level [RL23]
      assign key_press[gi] = (s2_reg[gi] == s3_reg[gi]) & s3_reg[gi] & ~key_lvl_reg[gi];
    end
  endgenerate

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      as1_reg <= 1'b1;
      as2_reg <= 1'b1;
      as3_reg <= 1'b1;
      auto_sw_reg <= 1'b1;
    end else begin
      as1_reg <= automatic_switch;
      as2_reg <= as1_reg;
      as3_reg <= as2_reg;
      if (as2_reg == as3_reg) begin
        auto_sw_reg <= as3_reg;
      end
    end
  end

  // console switch register
  reg [2:0] ctrl_reg;
  wire override = ctrl_reg[`CK_CTRL_OVERRIDE];
  wire cwbe = ctrl_reg[`CK_CTRL_CWBE];

  // and 2c: manual wanted and channels idle or masked [RL6] [RL11] [RL12]
  assign manual_status = ~auto_sw_reg & (override | ~channel_in_use);
  wire auto_status = ~manual_status;

  // key acceptance by status [RL9] [RL10] [RL24]
  reg [`CK_NKEYS-1:0] status_mask;
  always @* begin
    if (auto_status) begin
      status_mask = `CK_AUTO_MASK;
    end else begin
      status_mask = `CK_MANUAL_MASK;
    end
  end
  reg [`CK_CNT_W-1:0] lock_cnt_reg;
  wire locked = (lock_cnt_reg != {`CK_CNT_W{1'b0}});
  wire [`CK_NKEYS-1:0] key_ok = key_press & status_mask & {`CK_NKEYS{~locked}};
  wire any_accept = |key_ok;
  wire step_allowed = ~program_stop;
  wire sstep_go = key_ok[`CK_KEY_SSTEP] & step_allowed;
  wire mstep_go = key_ok[`CK_KEY_MSTEP] & step_allowed;

  // multiple step delay chain
  reg [2:0] ms_state_reg;
  reg [2:0] ms_state_next;
  reg [`CK_CNT_W-1:0] ms_cnt_reg;
  reg [`CK_CNT_W-1:0] ms_cnt_next;
  reg ms_fire;
  wire ms_cnt_end = (ms_cnt_reg == CNT_ONE);
  wire ms_hold = key_lvl_reg[`CK_KEY_MSTEP] & manual_status & step_allowed;

  always @* begin
    ms_state_next = ms_state_reg;
    ms_cnt_next = ms_cnt_reg;
    ms_fire = 1'b0;
    case (ms_state_reg)
      MS_IDLE: begin
        if (mstep_go) begin
          ms_state_next = MS_STAGE1;
          ms_cnt_next = STAGE_CYC;
        end
      end
      MS_STAGE1: begin
        if (!ms_hold) begin
          ms_state_next = MS_IDLE;
          ms_cnt_next = {`CK_CNT_W{1'b0}};
        end else if (ms_cnt_end) begin
          // first stage hands over to the second [RL5]
          ms_state_next = MS_STAGE2;
          ms_cnt_next = STAGE_CYC;
        end else begin
          ms_cnt_next = ms_cnt_reg - CNT_ONE;
        end
      end
      MS_STAGE2: begin
        if (!ms_hold) begin
          ms_state_next = MS_IDLE;
          ms_cnt_next = {`CK_CNT_W{1'b0}};
        end else if (ms_cnt_end) begin
          // second stage retriggers the first, new pulse [RL4] [RL5]
          ms_fire = 1'b1;
          ms_state_next = MS_STAGE1;
          ms_cnt_next = STAGE_CYC;
        end else begin
          ms_cnt_next = ms_cnt_reg - CNT_ONE;
        end
      end
      default: begin
        ms_state_next = MS_IDLE;
        ms_cnt_next = {`CK_CNT_W{1'b0}};
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_state_reg <= MS_IDLE;
      ms_cnt_reg <= {`CK_CNT_W{1'b0}};
    end else begin
      ms_state_reg <= ms_state_next;
      ms_cnt_reg <= ms_cnt_next;
    end
  end

  // any-key single shots: 30 ms lockout, 3 us output
  reg [`CK_CNT_W-1:0] ak_cnt_reg;
  wire ak_fire = any_accept | ms_fire;

  // step keys give no operation while the program is stopped [RL3]
  reg [`CK_NKEYS-1:0] key_op_next;
  always @* begin
    key_op_next = key_ok;
    if (program_stop) begin
      key_op_next[`CK_KEY_SSTEP] = 1'b0;
      key_op_next[`CK_KEY_MSTEP] = 1'b0;
    end
  end

  // lockout swallows contact bounce after an accepted key [RL23]
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_cnt_reg <= {`CK_CNT_W{1'b0}};
    end else begin
      if (any_accept) begin
        lock_cnt_reg <= LOCK_CYC;
      end else if (locked) begin
        lock_cnt_reg <= lock_cnt_reg - CNT_ONE;
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ak_cnt_reg <= {`CK_CNT_W{1'b0}};
      any_key_pulse <= 1'b0;
      step_pulse <= 1'b0;
      key_op <= {`CK_NKEYS{1'b0}};
    end else begin
      if (ak_fire) begin
        ak_cnt_reg <= ANY_CYC;
      end else if (ak_cnt_reg != {`CK_CNT_W{1'b0}}) begin
        ak_cnt_reg <= ak_cnt_reg - CNT_ONE;
      end
      any_key_pulse <= ak_fire | (ak_cnt_reg > CNT_ONE); // [RL1] [RL4]
      step_pulse <= sstep_go | mstep_go | ms_fire; // [RL2] [RL3]
      key_op <= key_op_next; // [RL3]
    end
  end

  // triggers
  reg reset_pend_reg;
  wire want_reset = key_ok[`CK_KEY_RESET] | key_ok[`CK_KEY_CLEAR];
  wire ilk_cause = power_on_reset | want_reset | key_ok[`CK_KEY_LOAD];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_pend_reg <= 1'b0;
      reset_trigger <= 1'b0;
      interlock_reset <= 1'b0;
    end else begin
      interlock_reset <= ilk_cause; // [RL21] [RL22]
      // reset waits for a3d1, drops at a2d1 [RL19] [RL20]
      if (want_reset) begin
        reset_pend_reg <= 1'b1;
      end else if (pulse_a3d1) begin
        reset_pend_reg <= 1'b0;
      end
      if (reset_pend_reg & pulse_a3d1) begin
        reset_trigger <= 1'b1;
      end else if (pulse_a2d1) begin
        reset_trigger <= 1'b0;
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_trigger <= 1'b0;
      program_stop <= 1'b0;
      master_stop <= 1'b1;
    end else begin
      // start trigger either status, cleared at a5d1 [RL14]
      if (key_ok[`CK_KEY_START]) begin
        start_trigger <= 1'b1;
      end else if (pulse_a5d1) begin
        start_trigger <= 1'b0;
      end
      // halt set wins over start and interlock clear [RL3] [RL10] [RL14]
      if (halt_instruction) begin
        program_stop <= 1'b1;
      end else if (key_ok[`CK_KEY_START] | interlock_reset) begin
        program_stop <= 1'b0;
      end
      if (interlock_reset | (manual_status & pulse_i1d2)) begin
        master_stop <= 1'b1; // [RL7] [RL22]
      end else if (auto_status & start_trigger & pulse_a4d2) begin
        master_stop <= 1'b0; // [RL15] [RL16]
      end
    end
  end

  assign channel_reset_command = interlock_reset | reset_trigger; // [RL19] [RL21]

  // word-bank execute during early i-cycles [RL17] [RL18]
  wire wb_fetch = cwbe & early_i_cycle;
  assign inhibit_ic_step = wb_fetch;
  assign inhibit_mdr_to_bus = wb_fetch;
  assign word_bank_to_bus = wb_fetch;
  assign word_bank_lamp = cwbe; // [RL18]
  assign override_lamp = override; // [RL13]
  assign interval_timer_run = ctrl_reg[`CK_CTRL_TIMER]; // [RL8]

  // ahb-lite slave, zero wait states
  reg wr_pend_reg;
  reg [7:0] wr_addr_reg;
  wire take = hsel & hready & htrans[1];
  wire ak_running = (ak_cnt_reg != {`CK_CNT_W{1'b0}});
  wire ms_running = ~ms_state_reg[0];
  wire [6:0] status_word = {ak_running, ms_running,
    manual_status, reset_trigger, start_trigger, program_stop, master_stop};
  reg [31:0] rd_mux;

  always @* begin
    case (haddr[7:0])
      `CK_OFS_CTRL: begin
        rd_mux = {29'h00000000, ctrl_reg};
      end
      `CK_OFS_STATUS: begin
        rd_mux = {25'h0000000, status_word};
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      ctrl_reg <= `CK_CTRL_RESET;
      hrdata <= 32'h00000000;
    end else begin
      wr_pend_reg <= take & hwrite;
      if (take) begin
        wr_addr_reg <= haddr[7:0];
      end
      if (wr_pend_reg && wr_addr_reg == `CK_OFS_CTRL) begin
        ctrl_reg <= hwdata[2:0];
      end
      if (take & ~hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

endmodule

// ### ck_console_key_monitor.sv
/*
  port checker for the console key control block.
  assumes it is bound to the top module on a single hclk domain.
*/
module ck_console_key_monitor (
  input wire hclk,
  input wire hresetn,
  input wire pulse_i1d2,
  input wire pulse_a2d1,
  input wire pulse_a3d1,
  input wire pulse_a4d2,
  input wire pulse_a5d1,
  input wire early_i_cycle,
  input wire halt_instruction,
  input wire any_key_pulse,
  input wire step_pulse,
  input wire master_stop,
  input wire program_stop,
  input wire start_trigger,
  input wire reset_trigger,
  input wire interlock_reset,
  input wire channel_reset_command,
  input wire manual_status,
  input wire inhibit_ic_step,
  input wire inhibit_mdr_to_bus,
  input wire word_bank_to_bus
);
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  AST_AKLEN: assert property ($rose(any_key_pulse) |-> ##299 any_key_pulse)
    else $error("key pulse too short");
  AST_STEP: assert property (step_pulse |-> !$past(program_stop))
    else $error("step while stopped");
  AST_HALT: assert property (halt_instruction |=> program_stop)
    else $error("halt missed");
  AST_A5: assert property (start_trigger && pulse_a5d1 |=> !start_trigger)
    else $error("start not cleared");
  AST_A4: assert property (start_trigger && pulse_a4d2 && !manual_status && !pulse_i1d2 &&
    !interlock_reset |=> !master_stop)
    else $error("master stop not cleared");
  AST_I1: assert property (manual_status && pulse_i1d2 |=> master_stop)
    else $error("manual stop missed");
  AST_RSET: assert property ($rose(reset_trigger) |-> $past(pulse_a3d1))
    else $error("reset set off time");
  AST_RCLR: assert property (reset_trigger && pulse_a2d1 && !pulse_a3d1 |=> !reset_trigger)
    else $error("reset not cleared");
  AST_ILR: assert property (interlock_reset && !halt_instruction |=>
    master_stop && !program_stop)
    else $error("interlock effect missing");
  AST_CHR: assert property (channel_reset_command == (interlock_reset | reset_trigger))
    else $error("channel reset wrong");
  AST_WB: assert property (word_bank_to_bus |-> early_i_cycle && inhibit_ic_step &&
    inhibit_mdr_to_bus)
    else $error("word bank path wrong");
endmodule

bind ck_console_key_control ck_console_key_monitor u_mon (.hclk, .hresetn, .pulse_i1d2,
  .pulse_a2d1, .pulse_a3d1, .pulse_a4d2, .pulse_a5d1, .early_i_cycle, .halt_instruction,
  .any_key_pulse, .step_pulse, .master_stop, .program_stop, .start_trigger, .reset_trigger,
  .interlock_reset, .channel_reset_command, .manual_status, .inhibit_ic_step,
  .inhibit_mdr_to_bus, .word_bank_to_bus);

// ### ck_ring_model.sv
/*
  timing ring model: one-cycle phase pulses over a ten-cycle ring.
  assumes the same hclk and hresetn as the block.
*/
module ck_ring_model (
  input wire hclk,
  input wire hresetn,
  output logic pulse_i1d2,
  output logic pulse_a2d1,
  output logic pulse_a3d1,
  output logic pulse_a4d2,
  output logic pulse_a5d1
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] ph_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ph_reg <= 4'h0;
    else ph_reg <= (ph_reg == 4'h9) ? 4'h0 : ph_reg + 4'h1;
  end
  assign pulse_i1d2 = ph_reg == 4'h1;
  assign pulse_a2d1 = ph_reg == 4'h3;
  assign pulse_a3d1 = ph_reg == 4'h5;
  assign pulse_a4d2 = ph_reg == 4'h7;
  assign pulse_a5d1 = ph_reg == 4'h9;
endmodule

// ### tb.sv
/*
  self-checking bench for console key control.
  assumes the ring model supplies the timing pulses.
*/
`include "ck_console_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [1:0] htrans = 2'h0;
  logic [8:0] key_pins = 9'h000;
  logic automatic_switch = 1'b1, power_on_reset = 1'b0, early_i_cycle = 1'b0;
  logic halt_instruction = 1'b0, channel_in_use = 1'b0, hit;
  wire [31:0] hrdata;
  wire [8:0] key_op;
  wire hreadyout, hresp, any_key_pulse, step_pulse, master_stop, program_stop;
  wire start_trigger, reset_trigger, interlock_reset, channel_reset_command;
  wire manual_status, inhibit_ic_step, inhibit_mdr_to_bus, word_bank_to_bus;
  wire override_lamp, word_bank_lamp, interval_timer_run;
  wire pulse_i1d2, pulse_a2d1, pulse_a3d1, pulse_a4d2, pulse_a5d1;
  int mismatches = 0, n_checks = 0, steps = 0, rts = 0, s0;
  ck_ring_model u_ring (.hclk, .hresetn, .pulse_i1d2, .pulse_a2d1, .pulse_a3d1,
    .pulse_a4d2, .pulse_a5d1);
  ck_console_key_control #(.STAGE_CYC(22'd20), .LOCK_CYC(22'd10)) DUT (.hclk, .hresetn,
    .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .key_pins, .automatic_switch, .power_on_reset, .pulse_i1d2,
    .pulse_a2d1, .pulse_a3d1, .pulse_a4d2, .pulse_a5d1, .early_i_cycle, .halt_instruction,
    .channel_in_use, .any_key_pulse, .step_pulse, .key_op, .master_stop, .program_stop,
    .start_trigger, .reset_trigger, .interlock_reset, .channel_reset_command, .manual_status,
    .inhibit_ic_step, .inhibit_mdr_to_bus, .word_bank_to_bus, .override_lamp,
    .word_bank_lamp, .interval_timer_run);
  always #5 hclk = ~hclk;
  always @(posedge hclk) begin
    if (step_pulse === 1'b1) steps <= steps + 1;
    if (reset_trigger === 1'b1) rts <= rts + 1;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  // key pressed at a5d1, just before a ring wrap, held 12 cycles, then lockout gap
  task press(input int k);
    hit = 1'b0;
    @(posedge hclk);
    while (pulse_a5d1 !== 1'b1) @(posedge hclk);
    key_pins[k] <= 1'b1;
    repeat (12) begin
      @(posedge hclk);
      if (key_op[k] === 1'b1) hit = 1'b1;
    end
    key_pins[k] <= 1'b0;
    repeat (30) @(posedge hclk);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #300000;
    mismatches++;
    end_sim;
  end
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, 32'h0, 32'h0);
    chk(rd, 32'h0);
    chk({hreadyout, hresp}, 2'h2);
    xfer(1'b0, 32'h4, 32'h0);
    chk(rd[1:0], 2'h1);
    xfer(1'b1, 32'h0, 32'h7);
    xfer(1'b0, 32'h8, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b0, 32'h0, 32'h0);
    chk(rd, 32'h7);
    chk({override_lamp, word_bank_lamp, interval_timer_run}, 3'h7);
    early_i_cycle <= 1'b1;
    repeat (2) @(posedge hclk);
    chk({word_bank_to_bus, inhibit_ic_step, inhibit_mdr_to_bus}, 3'h7);
    early_i_cycle <= 1'b0;
    xfer(1'b1, 32'h0, 32'h0);
    @(posedge hclk);
    chk({override_lamp, word_bank_lamp, word_bank_to_bus}, 3'h0);
    $display("test registers done");
    for (int k = 0; k < 9; k++) begin
      press(k);
      chk(hit, (`CK_AUTO_MASK >> k) & 9'h001);
    end
    press(2);
    chk({master_stop, start_trigger, program_stop}, 3'h0);
    $display("test automatic done");
    automatic_switch <= 1'b0;
    channel_in_use <= 1'b1;
    repeat (30) @(posedge hclk);
    chk({manual_status, master_stop}, 2'h0);
    xfer(1'b1, 32'h0, 32'h1);
    repeat (20) @(posedge hclk);
    chk({manual_status, master_stop}, 2'h3);
    xfer(1'b1, 32'h0, 32'h0);
    repeat (3) @(posedge hclk);
    chk(manual_status, 1'b0);
    channel_in_use <= 1'b0;
    repeat (20) @(posedge hclk);
    chk({manual_status, master_stop}, 2'h3);
    for (int k = 0; k < 9; k++) begin
      press(k);
      chk(hit, (`CK_MANUAL_MASK >> k) & 9'h001);
    end
    halt_instruction <= 1'b1;
    @(posedge hclk);
    halt_instruction <= 1'b0;
    @(posedge hclk);
    chk(program_stop, 1'b1);
    s0 = steps;
    press(3);
    chk(steps - s0, 0);
    press(2);
    chk({program_stop, master_stop}, 2'h1);
    s0 = steps;
    press(3);
    chk(steps - s0, 1);
    s0 = steps;
    key_pins[4] <= 1'b1;
    while (steps == s0) @(posedge hclk);
    s0 = steps;
    repeat (189) @(posedge hclk);
    chk(steps - s0, 4);
    key_pins[4] <= 1'b0;
    repeat (60) @(posedge hclk);
    s0 = steps;
    repeat (100) @(posedge hclk);
    chk(steps - s0, 0);
    $display("test manual done");
    automatic_switch <= 1'b1;
    repeat (10) @(posedge hclk);
    s0 = rts;
    press(1);
    chk(rts - s0, 8);
    chk(master_stop, 1'b1);
    press(2);
    chk(master_stop, 1'b0);
    power_on_reset <= 1'b1;
    @(posedge hclk);
    power_on_reset <= 1'b0;
    repeat (3) @(posedge hclk);
    chk({master_stop, program_stop}, 2'h2);
    $display("test reset done");
    end_sim;
  end
endmodule
